// [mfr_pkg.sv]
package mfr_pkg;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int SENSE_W  = 8;    // sense amp and threshold word width
    localparam int RETRY_W  = 4;    // cycle-limit retry count field width
    localparam int MODE_W   = 4;    // response select field width
    localparam int TIMER_W  = 24;   // lock retry timer width

    localparam logic [MODE_W-1:0] CBC_REPORT_ONLY = 4'h6;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 50;       // 20 MHz system clock
    localparam int LOCK_RETRY_US    = 100000;   // lock retry interval in us
    localparam int LOCK_RETRY_CYC   = LOCK_RETRY_US * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        STG_NORMAL = 3'h0,
        STG_HIZ    = 3'h1,
        STG_RECIRC = 3'h2,
        STG_HSB    = 3'h3,
        STG_LSB    = 3'h4
    } mfr_stage_e;

    typedef enum logic [2:0]
    {
        ACT_IDLE  = 3'h1,
        ACT_LATCH = 3'h2,
        ACT_RETRY = 3'h4
    } mfr_act_e;

    typedef struct packed
    {
        logic motor_lock_fault;
        logic lock_limit_fault;
        logic cycle_limit_fault;
    } mfr_flags_s;

    typedef struct packed
    {
        logic [MODE_W-1:0]  motor_lock_response_select;
        logic [MODE_W-1:0]  cycle_limit_response_select;
        logic [MODE_W-1:0]  lock_limit_response_select;
        logic [RETRY_W-1:0] cycle_limit_retry_count;
    } mfr_cfg_s;

    localparam mfr_flags_s FLAGS_RST = '0;

endpackage

// [mfr_fault_response.sv]
// Notes on behaviour
// - motor lock codes 0000-0011 latch; hi-z, high brake or low brake until cleared
// - motor lock codes 0100-0111 apply same states, resume after lock retry interval
// - motor lock fault is abnormal speed, no motor or lost sync
// - reporting lock modes pull pin low and set flag; 1000 report only; 1xx1 nothing
// - cycle limit over threshold switches power stage to recirculation when acting
// - cycle limit recovers next pwm, below threshold or after retry count; even codes below 1000 report
// - cycle limit 0110 reports only; 0111 and 1xxx do nothing
// - lock current limit reports except 1xx1; low bits choose state; 0xxx latch or retry by bit 2
// - latched beats retry beats cycle limit beats report; retry waits longest pending
// - fault pin low while any latched or retrying fault is in effect

// ----------------------------------------------------------------
// one fault's action tracker: idle, latched or retrying
// ----------------------------------------------------------------
module mfr_act
    import mfr_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // fault and configuration
    input  wire logic       det,
    input  wire logic       act_en,
    input  wire logic       latch_sel,
    input  mfr_stage_e      stage_sel,
    input  wire logic       clear,
    input  wire logic       retry_done,
    // state
    output mfr_act_e        st_q,
    output mfr_stage_e      stage_q
);
    mfr_act_e   st_d;
    mfr_stage_e stage_d;

    // next state; stage is captured at entry so mode edits do not glitch it
    always_comb
    begin
        st_d    = st_q;
        stage_d = stage_q;
        case (st_q)
            ACT_IDLE:
            begin
                if (det && act_en)
                begin
                    st_d    = latch_sel ? ACT_LATCH : ACT_RETRY;
                    stage_d = stage_sel;
                end
            end
            ACT_LATCH:
            begin
                if (clear && !det)
                    st_d = ACT_IDLE;
            end
            ACT_RETRY:
            begin
                if (retry_done)
                    st_d = ACT_IDLE;
            end
            default:
                st_d = ACT_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q    <= ACT_IDLE;
            stage_q <= STG_HIZ;
        end
        else
        begin
            st_q    <= st_d;
            stage_q <= stage_d;
        end
    end
endmodule

// ----------------------------------------------------------------
// top: fault response for lock, cycle limit and lock current limit
// ----------------------------------------------------------------
module mfr_fault_response
    import mfr_pkg::*;
#(
    parameter int LOCK_RETRY_CYCLES = LOCK_RETRY_CYC
)
(
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // detectors, from same-clock logic
    input  wire logic               speed_abnormal,
    input  wire logic               no_motor,
    input  wire logic               sync_lost,
    input  wire logic               pwm_cycle_start,
    input  wire logic [SENSE_W-1:0] sense_amp_output_voltage,
    input  wire logic [SENSE_W-1:0] cycle_limit_threshold,
    input  wire logic [SENSE_W-1:0] lock_current_threshold,
    // configuration and control
    input  mfr_cfg_s                cfg,
    input  wire logic               fault_clear_bit,
    // outputs
    output mfr_stage_e              stage_cmd_q,
    output logic                    fault_pin_n_q,
    output mfr_flags_s              controller_fault_flags_q
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [MODE_W-1:0] ml_m;
    logic [MODE_W-1:0] cl_m;
    logic [MODE_W-1:0] ll_m;
    logic              ml_det;
    logic              cl_det;
    logic              ll_det;
    logic              ml_rep;
    logic              cl_rep;
    logic              ll_rep;
    logic              cl_act_en;
    mfr_stage_e        ml_sel;
    mfr_stage_e        ll_sel;

    assign ml_m      = cfg.motor_lock_response_select;
    assign cl_m      = cfg.cycle_limit_response_select;
    assign ll_m      = cfg.lock_limit_response_select;
    assign ml_det    = speed_abnormal | no_motor | sync_lost;
    assign cl_det    = sense_amp_output_voltage > cycle_limit_threshold;
    assign ll_det    = sense_amp_output_voltage > lock_current_threshold;
    assign ml_rep    = !ml_m[3] || !ml_m[0];
    assign cl_rep    = !cl_m[3] && !cl_m[0];
    assign ll_rep    = !ll_m[3] || !ll_m[0];
    assign cl_act_en = !cl_m[3] && (cl_m != CBC_REPORT_ONLY) && (cl_m[2:0] != 3'h7);
    assign ml_sel    = !ml_m[1] ? STG_HIZ : (ml_m[0] ? STG_LSB : STG_HSB);

    // lock limit low bits pick the state
    always_comb
    begin
        case (ll_m[1:0])
            2'h0:    ll_sel = STG_HIZ;
            2'h1:    ll_sel = STG_RECIRC;
            2'h2:    ll_sel = STG_HSB;
            default: ll_sel = STG_LSB;
        endcase
    end

    // ------------------------------------------------------------
    // lock fault trackers and shared retry timer
    // ------------------------------------------------------------
    mfr_act_e     ml_st;
    mfr_act_e     ll_st;
    mfr_stage_e   ml_stage;
    mfr_stage_e   ll_stage;
    logic         retry_done;
    logic         any_retry;
    logic         retry_hold;
    logic [TIMER_W-1:0] tmr_q;
    logic [TIMER_W-1:0] tmr_d;

    mfr_act u_ml
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .det        (ml_det),
        .act_en     (!ml_m[3]),
        .latch_sel  (!ml_m[2]),
        .stage_sel  (ml_sel),
        .clear      (fault_clear_bit),
        .retry_done (retry_done),
        .st_q       (ml_st),
        .stage_q    (ml_stage)
    );

    mfr_act u_ll
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .det        (ll_det),
        .act_en     (!ll_m[3]),
        .latch_sel  (!ll_m[2]),
        .stage_sel  (ll_sel),
        .clear      (fault_clear_bit),
        .retry_done (retry_done),
        .st_q       (ll_st),
        .stage_q    (ll_stage)
    );

    // one timer for both: it restarts while any retrying fault persists,
    // so release follows the longest pending wait
    assign any_retry  = (ml_st == ACT_RETRY) || (ll_st == ACT_RETRY);
    assign retry_hold = (ml_det && ml_st == ACT_RETRY) || (ll_det && ll_st == ACT_RETRY);
    assign retry_done = any_retry && !retry_hold
                        && (tmr_q == TIMER_W'(LOCK_RETRY_CYCLES - 1));

    always_comb
    begin
        if (!any_retry || retry_hold || retry_done)
            tmr_d = '0;
        else
            tmr_d = tmr_q + TIMER_W'(1);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tmr_q <= '0;
        else
            tmr_q <= tmr_d;
    end

    // ------------------------------------------------------------
    // cycle-by-cycle limit
    // ------------------------------------------------------------
    logic             cl_on_q;
    logic             cl_on_d;
    logic [RETRY_W:0] cl_cnt_q;
    logic [RETRY_W:0] cl_cnt_d;

    // recovery path picked by bits 2:1 of the mode
    always_comb
    begin
        cl_on_d  = cl_on_q;
        cl_cnt_d = cl_cnt_q;
        if (!cl_on_q)
        begin
            if (cl_det && cl_act_en)
            begin
                cl_on_d  = 1'b1;
                cl_cnt_d = '0;
            end
        end
        else if (!cl_act_en)
            cl_on_d = 1'b0;
        else
        begin
            case (cl_m[2:1])
                2'h0:    cl_on_d = !pwm_cycle_start;
                2'h1:    cl_on_d = cl_det;
                default:
                begin
                    if (pwm_cycle_start)
                    begin
                        if (cl_cnt_q >= {1'b0, cfg.cycle_limit_retry_count})
                            cl_on_d = 1'b0;
                        else
                            cl_cnt_d = cl_cnt_q + (RETRY_W+1)'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cl_on_q  <= 1'b0;
            cl_cnt_q <= '0;
        end
        else
        begin
            cl_on_q  <= cl_on_d;
            cl_cnt_q <= cl_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // flags, pin and stage command
    // ------------------------------------------------------------
    mfr_flags_s flags_d;
    mfr_stage_e stage_d;
    logic       pin_n_d;

    // a new detection in the clear cycle wins over the clear
    always_comb
    begin
        flags_d = fault_clear_bit ? FLAGS_RST : controller_fault_flags_q;
        if (ml_det && ml_rep)
            flags_d.motor_lock_fault = 1'b1;
        if (cl_det && cl_rep)
            flags_d.cycle_limit_fault = 1'b1;
        if (ll_det && ll_rep)
            flags_d.lock_limit_fault = 1'b1;
    end

    // latched first, then lock retries, then the per-cycle limit
    always_comb
    begin
        if (ml_st == ACT_LATCH)
            stage_d = ml_stage;
        else if (ll_st == ACT_LATCH)
            stage_d = ll_stage;
        else if (ml_st == ACT_RETRY)
            stage_d = ml_stage;
        else if (ll_st == ACT_RETRY)
            stage_d = ll_stage;
        else if (cl_on_q)
            stage_d = STG_RECIRC;
        else
            stage_d = STG_NORMAL;
        pin_n_d = !((ml_st != ACT_IDLE) || (ll_st != ACT_IDLE)
                    || (|controller_fault_flags_q));
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_cmd_q              <= STG_NORMAL;
            fault_pin_n_q            <= 1'b1;
            controller_fault_flags_q <= FLAGS_RST;
        end
        else
        begin
            stage_cmd_q              <= stage_d;
            fault_pin_n_q            <= pin_n_d;
            controller_fault_flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_ml_entry;
        ml_st == ACT_IDLE && ml_det && !ml_m[3];
    endsequence

    property p_ml_enter;
        @(posedge mclk) disable iff (!rst_n)
        s_ml_entry |=> (ml_st == (ml_m[2] ? ACT_RETRY : ACT_LATCH)) ##1 (stage_cmd_q != STG_NORMAL);
    endproperty
    a_ml_enter: assert property (p_ml_enter) else $error("lock entry wrong");

    property p_latch_hold;
        @(posedge mclk) disable iff (!rst_n)
        ml_st == ACT_LATCH && !fault_clear_bit |=> ml_st == ACT_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

    property p_ml_lsb;
        @(posedge mclk) disable iff (!rst_n)
        ml_st == ACT_LATCH && ml_stage == STG_LSB |=> stage_cmd_q == STG_LSB;
    endproperty
    a_ml_lsb: assert property (p_ml_lsb) else $error("latched stage lost");

    property p_pin_low;
        @(posedge mclk) disable iff (!rst_n)
        (ml_st != ACT_IDLE || ll_st != ACT_IDLE) |=> !fault_pin_n_q;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("fault pin high");

    property p_ml_silent;
        @(posedge mclk) disable iff (!rst_n)
        ml_m[3] && ml_m[0] && ml_st == ACT_IDLE && !controller_fault_flags_q.motor_lock_fault
        |=> ml_st == ACT_IDLE && !controller_fault_flags_q.motor_lock_fault;
    endproperty
    a_ml_silent: assert property (p_ml_silent) else $error("lock mode not silent");

    property p_ml_report;
        @(posedge mclk) disable iff (!rst_n)
        ml_det && ml_m == 4'h8 |=> controller_fault_flags_q.motor_lock_fault ##1 !fault_pin_n_q;
    endproperty
    a_ml_report: assert property (p_ml_report) else $error("lock report missing");

    property p_cl_recirc;
        @(posedge mclk) disable iff (!rst_n)
        cl_on_q && ml_st == ACT_IDLE && ll_st == ACT_IDLE |=> stage_cmd_q == STG_RECIRC;
    endproperty
    a_cl_recirc: assert property (p_cl_recirc) else $error("no recirculation");

    property p_cl_odd;
        @(posedge mclk) disable iff (!rst_n)
        cl_m[0] && !fault_clear_bit |=> $stable(controller_fault_flags_q.cycle_limit_fault);
    endproperty
    a_cl_odd: assert property (p_cl_odd) else $error("odd code reported");

    property p_cl_off;
        @(posedge mclk) disable iff (!rst_n)
        cl_m[3] || cl_m == CBC_REPORT_ONLY |=> !cl_on_q;
    endproperty
    a_cl_off: assert property (p_cl_off) else $error("cycle limit acted");

    property p_timer_bound;
        @(posedge mclk) disable iff (!rst_n)
        tmr_q < TIMER_W'(LOCK_RETRY_CYCLES);
    endproperty
    a_timer_bound: assert property (p_timer_bound) else $error("retry timer overrun");

    // a retrying lock fault may only let go on the last count of the shared timer
    property p_retry_early;
        @(posedge mclk) disable iff (!rst_n)
        ml_st == ACT_RETRY && tmr_q != TIMER_W'(LOCK_RETRY_CYCLES - 1) |=> ml_st == ACT_RETRY;
    endproperty
    a_retry_early: assert property (p_retry_early) else $error("lock retry ended early");
endmodule

// [mfr_fault_response_bench.sv]
module mfr_fault_response_bench
    import mfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    // short retry interval keeps retry scenarios to tens of cycles
    localparam int RETRY = 20;

    logic               mclk;
    logic               rst_n;
    logic               speed_abnormal;
    logic               no_motor;
    logic               sync_lost;
    logic               pwm_cycle_start;
    logic               fault_clear_bit;
    logic [SENSE_W-1:0] vsense;
    logic [SENSE_W-1:0] cbc_thr;
    logic [SENSE_W-1:0] lock_thr;
    mfr_cfg_s           cfg;
    mfr_stage_e         stage;
    logic               pin_n;
    mfr_flags_s         flags;
    int                 fail_count;
    int                 n_compared;
    mfr_stage_e         st_tab [4] = '{STG_HIZ, STG_RECIRC, STG_HSB, STG_LSB};

    mfr_fault_response #(.LOCK_RETRY_CYCLES(RETRY)) dut
    (
        .mclk                     (mclk),
        .rst_n                    (rst_n),
        .speed_abnormal           (speed_abnormal),
        .no_motor                 (no_motor),
        .sync_lost                (sync_lost),
        .pwm_cycle_start          (pwm_cycle_start),
        .sense_amp_output_voltage (vsense),
        .cycle_limit_threshold    (cbc_thr),
        .lock_current_threshold   (lock_thr),
        .cfg                      (cfg),
        .fault_clear_bit          (fault_clear_bit),
        .stage_cmd_q              (stage),
        .fault_pin_n_q            (pin_n),
        .controller_fault_flags_q (flags)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // inputs always move 5 ns after the edge, never on it
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic expect_out(input mfr_stage_e s, input logic p, input logic [2:0] f);
        chk({5'h0, stage}, {5'h0, s});
        chk({7'h0, pin_n}, {7'h0, p});
        chk({5'h0, flags}, {5'h0, f});
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // clear pulse with detectors already gone returns everything to idle
    task automatic clear_all;
        fault_clear_bit = 1'b1;
        step(1);
        fault_clear_bit = 1'b0;
        step(2);
        expect_out(STG_NORMAL, 1'b1, 3'h0);
    endtask

    // bounded wait for the power stage to come back
    task automatic wait_normal(input int lim);
        int k;
        k = 0;
        while (stage !== STG_NORMAL && k < lim)
        begin
            step(1);
            k++;
        end
        chk({7'h0, stage === STG_NORMAL}, 8'h1);
        if (k >= lim)
            test_done();
    endtask

    task automatic pwm_pulse;
        pwm_cycle_start = 1'b1;
        step(1);
        pwm_cycle_start = 1'b0;
        step(2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // latched lock modes, each detector in turn, one refused clear
    task automatic t_lock_latched;
        mfr_stage_e s;
        for (int m = 0; m < 4; m++)
        begin
            s = (m < 2) ? STG_HIZ : st_tab[m];
            cfg.motor_lock_response_select = 4'(m);
            {speed_abnormal, no_motor, sync_lost} = 3'h1 << (m % 3);
            step(3);
            expect_out(s, 1'b0, 3'h4);
            if (m == 3)
            begin
                fault_clear_bit = 1'b1;
                step(1);
                fault_clear_bit = 1'b0;
                step(2);
                expect_out(s, 1'b0, 3'h4);
            end
            {speed_abnormal, no_motor, sync_lost} = 3'h0;
            step(RETRY + 5);
            expect_out(s, 1'b0, 3'h4);
            clear_all();
        end
    endtask

    // retry lock modes resume only after the retry interval
    task automatic t_lock_retry;
        for (int m = 4; m < 8; m++)
        begin
            cfg.motor_lock_response_select = 4'(m);
            no_motor = 1'b1;
            step(3);
            expect_out((m < 6) ? STG_HIZ : st_tab[m % 4], 1'b0, 3'h4);
            no_motor = 1'b0;
            step(RETRY - 1);
            chk({5'h0, stage}, {5'h0, (m < 6) ? STG_HIZ : st_tab[m % 4]});
            wait_normal(RETRY + 5);
            clear_all();
        end
    endtask

    // report only and fully disabled lock codes
    task automatic t_lock_report;
        logic [3:0] codes [6] = '{4'h8, 4'h9, 4'hb, 4'hd, 4'hf, 4'he};
        foreach (codes[i])
        begin
            cfg.motor_lock_response_select = codes[i];
            speed_abnormal = 1'b1;
            step(3);
            expect_out(STG_NORMAL, codes[i][0], codes[i][0] ? 3'h0 : 3'h4);
            speed_abnormal = 1'b0;
            clear_all();
        end
    endtask

    // cycle limit codes 0 to 8, each acting code 0 to 5 with its own way out
    task automatic t_cycle_limit;
        logic rep;
        cfg.motor_lock_response_select = 4'h9;
        for (int m = 0; m < 9; m++)
        begin
            rep = (m == 0 || m == 2 || m == 4 || m == 6);
            cfg.cycle_limit_response_select = 4'(m);
            vsense = 8'h50;
            step(3);
            expect_out((m < 6) ? STG_RECIRC : STG_NORMAL, !rep, {2'h0, rep});
            vsense = 8'h10;
            step(3);
            if (m < 2)
            begin
                chk({5'h0, stage}, {5'h0, STG_RECIRC});
                pwm_pulse();
            end
            else if (m == 4 || m == 5)
            begin
                pwm_pulse();
                pwm_pulse();
                chk({5'h0, stage}, {5'h0, STG_RECIRC});
                pwm_pulse();
            end
            chk({5'h0, stage}, {5'h0, STG_NORMAL});
            clear_all();
        end
    endtask

    // lock current limit: all eight acting codes
    task automatic t_lock_limit;
        cfg.cycle_limit_response_select = 4'h8;
        for (int m = 0; m < 8; m++)
        begin
            cfg.lock_limit_response_select = 4'(m);
            vsense = 8'h90;
            step(3);
            expect_out(st_tab[m % 4], 1'b0, 3'h2);
            vsense = 8'h10;
            step((m < 4) ? RETRY + 5 : RETRY - 1);
            chk({5'h0, stage}, {5'h0, st_tab[m % 4]});
            if (m >= 4)
                wait_normal(RETRY + 5);
            clear_all();
        end
        // report-only and silent lock limit codes leave the power stage alone
        for (int m = 8; m < 10; m++)
        begin
            cfg.lock_limit_response_select = 4'(m);
            vsense = 8'h90;
            step(3);
            expect_out(STG_NORMAL, m[0], m[0] ? 3'h0 : 3'h2);
            vsense = 8'h10;
            clear_all();
        end
    endtask

    // latched beats retry; retry waits for the last fault to go
    task automatic t_priority;
        cfg.motor_lock_response_select = 4'h3;
        cfg.lock_limit_response_select = 4'h4;
        sync_lost = 1'b1;
        vsense = 8'h90;
        step(3);
        expect_out(STG_LSB, 1'b0, 3'h6);
        sync_lost = 1'b0;
        vsense = 8'h10;
        step(RETRY + 10);
        chk({5'h0, stage}, {5'h0, STG_LSB});
        clear_all();
        cfg.motor_lock_response_select = 4'h6;
        cfg.cycle_limit_response_select = 4'h2;
        sync_lost = 1'b1;
        vsense = 8'h90;
        step(3);
        expect_out(STG_HSB, 1'b0, 3'h7);
        sync_lost = 1'b0;
        step(10);
        vsense = 8'h10;
        step(RETRY - 1);
        chk({5'h0, stage}, {5'h0, STG_HSB});
        wait_normal(RETRY + 5);
        clear_all();
    endtask

    // ------------------------------------------------------------
    // clock, reset and sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial
    begin
        fail_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        {speed_abnormal, no_motor, sync_lost} = 3'h0;
        pwm_cycle_start = 1'b0;
        fault_clear_bit = 1'b0;
        vsense = 8'h10;
        cbc_thr = 8'h40;
        lock_thr = 8'h80;
        cfg = '{4'h9, 4'h8, 4'h9, 4'h2};
        step(10);
        rst_n = 1'b1;
        step(2);
        expect_out(STG_NORMAL, 1'b1, 3'h0);
        t_lock_latched();
        t_lock_retry();
        t_lock_report();
        t_cycle_limit();
        t_lock_limit();
        t_priority();
        test_done();
    end
endmodule
